// ---- mdsec_defines.svh ----
// buffer word indices, field positions, reset values and bus codes
// assumes: included by bare name from the top module
`ifndef MDSEC_DEFINES_SVH
`define MDSEC_DEFINES_SVH

// buffer word indices; byte address on the bus is four times the index
`define MDSEC_IDX_CFG_FIRST   7'h00
`define MDSEC_IDX_CFG_LAST    7'h02
`define MDSEC_IDX_GUARD_LAST  7'h03
`define MDSEC_IDX_RX_BASE     7'h10
`define MDSEC_IDX_RX_LAST     7'h2F
`define MDSEC_IDX_TX_BASE     7'h30
`define MDSEC_IDX_TX_LAST     7'h3F
`define MDSEC_IDX_ERR_CODE    7'h50
`define MDSEC_IDX_BUF_LAST    7'h5F
`define MDSEC_IDX_IRQ_STATUS  7'h60
`define MDSEC_IDX_IRQ_MASK    7'h61
`define MDSEC_IDX_FLAGS       7'h62

// buffer geometry
`define MDSEC_BUF_WORDS       96
`define MDSEC_WORD_W          16

// interrupt status / mask bit positions
`define MDSEC_IRQ_PRE_ERR     0
`define MDSEC_IRQ_DATA_ERR    1
`define MDSEC_IRQ_SEQ_UP      2
`define MDSEC_IRQ_W           3

// flags word bit positions
`define MDSEC_FLG_SEQ_ACTIVE  0
`define MDSEC_FLG_PRE_ERR     1
`define MDSEC_FLG_DATA_ERR    2
`define MDSEC_FLG_MULTI       3
`define MDSEC_FLG_TX_EN       4

// reset values
`define MDSEC_WORD_RST        16'h0000
`define MDSEC_IRQ_RST         3'h0
`define MDSEC_CFG_RST         48'h0000_0000_0000

// bus answer codes
`define MDSEC_RESP_OKAY       2'h0
`define MDSEC_RESP_SLVERR     2'h2

`endif

// ---- mdsec_master_model.sv ----
// master station on the serial line, as seen through the link events
// assumes: events are single-cycle pulses on the block's clock
`timescale 1ns/1ps
`default_nettype none

module mdsec_master_model (
  input  wire logic                       clk_i,
  output var  mdsec_pkg::mdsec_link_evt_t evt_o
);
  initial evt_o = '0;

  // k: 0 start, 1 pre done, 2 data done, 3 error, 4 point in, 5 point out
  // only the master begins a new pre-sequence, also after a dropped slave
  task automatic ev(input int k, input logic [15:0] d);
    mdsec_pkg::mdsec_link_evt_t e;
    e = '0;
    e.pre_start = (k == 0);
    e.pre_ok = (k == 1);
    e.data_ok = (k == 2);
    e.err = (k == 3);
    e.err_code = d;
    e.rx_we = (k == 4);
    e.rx_idx = d[12:8];
    e.rx_byte = d[7:0];
    e.tx_req = (k == 5);
    e.tx_idx = d[11:8];
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask
endmodule

`default_nettype wire

// ---- mdsec_pkg.sv ----
// types shared by the slave-station error control block
// assumes: compiled before every module of the block
package mdsec_pkg;

  // sequence progress as seen by the local station
  typedef enum logic [1:0] {
    mdsec_st_wait = 2'b00,
    mdsec_st_pre  = 2'b01,
    mdsec_st_data = 2'b10,
    mdsec_st_run  = 2'b11
  } mdsec_state_t;

  // one-cycle events from the serial link engine, same clock
  typedef struct packed {
    logic        pre_start;
    logic        pre_ok;
    logic        data_ok;
    logic        err;
    logic [15:0] err_code;
    logic        rx_we;
    logic [4:0]  rx_idx;
    logic [7:0]  rx_byte;
    logic        tx_req;
    logic [3:0]  tx_idx;
  } mdsec_link_evt_t;

  // status flags seen by the host controller
  typedef struct packed {
    logic data_seq_error_flag;
    logic pre_seq_error_flag;
    logic seq_active_flag;
  } mdsec_flags_t;

endpackage

// ---- mdsec_sync3.sv ----
// three-stage synchroniser for a level from a pin
// assumes: input is asynchronous to clk_i; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module mdsec_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic async_i,
  output var  logic level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_o <= RST_VAL;
    end else if (s2_reg == s3_reg) begin
      level_o <= s3_reg;
    end
  end

endmodule

`default_nettype wire

// ---- mdsec_top.sv ----
// slave-station error control and buffer memory for a multidrop serial link
// assumes: link engine events arrive on clk_i; host reaches the buffer over AXI4-Lite
//
// Overview of operation
// - pre-sequence error stops transmit, sets pre flag, lamp, stores code at word 50H.
// - pre flag clears by itself when a later pre-sequence finishes cleanly.
// - data-sequence error stops link, sets data flag, lamp, stores code at word 50H.
// - data-sequence error drops active flag and raises data flag together.
// - single slave: data flag clears when restarted pre-sequence completes.
// - single slave: active flag returns after first data sequence after restart.
// - data-sequence error leaves received data area untouched.
// - several slaves: first data sequence after restart sets active, clears data flag.
// - host reset or power-up returns the whole buffer to initial contents.
// - pre-sequence copies buffer words 0H to 2H into operating configuration.
// - host bytes in transmit area go to master; first eight points at 30H.
// - points from master land in receive area; first eight at word 10H.
// - buffer layout is the same for 256 or 512 master points.
// - word 50H keeps latest error; only host reset clears it.
// - active flag high only in normal data sequences, low in pre or error.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mdsec_defines.svh"

module mdsec_top #(
  parameter int BUF_WORDS = `MDSEC_BUF_WORDS,
  parameter int ADDR_W    = 9
) (
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr_i,
  input  wire logic                     s_axi_awvalid_i,
  output var  logic                     s_axi_awready_o,
  input  wire logic [31:0]              s_axi_wdata_i,
  input  wire logic [3:0]               s_axi_wstrb_i,
  input  wire logic                     s_axi_wvalid_i,
  output var  logic                     s_axi_wready_o,
  output var  logic [1:0]               s_axi_bresp_o,
  output var  logic                     s_axi_bvalid_o,
  input  wire logic                     s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]        s_axi_araddr_i,
  input  wire logic                     s_axi_arvalid_i,
  output var  logic                     s_axi_arready_o,
  output var  logic [31:0]              s_axi_rdata_o,
  output var  logic [1:0]               s_axi_rresp_o,
  output var  logic                     s_axi_rvalid_o,
  input  wire logic                     s_axi_rready_i,
  // link engine side
  input  wire mdsec_pkg::mdsec_link_evt_t link_evt_i,
  input  wire logic                     multi_slave_select_switch_i,
  output var  logic [7:0]               tx_byte_o,
  output var  logic                     tx_byte_valid_o,
  output var  logic                     tx_enable_o,
  output var  logic [47:0]              op_cfg_o,
  // host status
  output var  mdsec_pkg::mdsec_flags_t  flags_o,
  output var  logic                     link_error_lamp_o,
  output var  logic                     irq_o
);

  if (BUF_WORDS != `MDSEC_BUF_WORDS) begin : g_chk_words
    $error("buffer depth must match the fixed word map");
  end
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_chk_addr
    $error("address width must cover the status words");
  end

  localparam logic [6:0] IDX_CFG_FIRST  = `MDSEC_IDX_CFG_FIRST;
  localparam logic [6:0] IDX_CFG_LAST   = `MDSEC_IDX_CFG_LAST;
  localparam logic [6:0] IDX_RX_BASE    = `MDSEC_IDX_RX_BASE;
  localparam logic [6:0] IDX_RX_LAST    = `MDSEC_IDX_RX_LAST;
  localparam logic [6:0] IDX_TX_BASE    = `MDSEC_IDX_TX_BASE;
  localparam logic [6:0] IDX_ERR_CODE   = `MDSEC_IDX_ERR_CODE;
  localparam logic [6:0] IDX_BUF_LAST   = `MDSEC_IDX_BUF_LAST;
  localparam logic [6:0] IDX_IRQ_STATUS = `MDSEC_IDX_IRQ_STATUS;
  localparam logic [6:0] IDX_IRQ_MASK   = `MDSEC_IDX_IRQ_MASK;
  localparam logic [6:0] IDX_FLAGS      = `MDSEC_IDX_FLAGS;

  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  logic [15:0]                buf_reg [BUF_WORDS];
  mdsec_pkg::mdsec_state_t    state_reg;
  logic [`MDSEC_IRQ_W-1:0]    irq_status_reg;
  logic [`MDSEC_IRQ_W-1:0]    irq_mask_reg;
  logic                       multi_sync;

  // bus capture
  logic [6:0]                 aw_idx_reg;
  logic                       aw_have_reg;
  logic [15:0]                w_data_reg;
  logic [1:0]                 w_strb_reg;
  logic                       w_have_reg;
  logic                       wr_fire;
  logic [6:0]                 ar_idx;
  logic [15:0]                wr_merged;
  logic [`MDSEC_IRQ_W-1:0]    irq_set;
  logic [`MDSEC_IRQ_W-1:0]    irq_clr;
  logic                       pre_err_ev;
  logic                       data_err_ev;
  logic                       seq_up_ev;

  mdsec_sync3 #(
    .RST_VAL (1'b0)
  ) u_multi_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (multi_slave_select_switch_i),
    .level_o  (multi_sync)
  );

  // ---------------------------------------------------------------
  // sequence events
  // ---------------------------------------------------------------
  // an error counts against whichever sequence is under way
  assign pre_err_ev  = link_evt_i.err && (state_reg == mdsec_pkg::mdsec_st_pre);
  assign data_err_ev = link_evt_i.err && (state_reg == mdsec_pkg::mdsec_st_data ||
                                          state_reg == mdsec_pkg::mdsec_st_run);
  assign seq_up_ev   = link_evt_i.data_ok && (state_reg == mdsec_pkg::mdsec_st_data);

  // only the master's new pre-sequence leaves the wait state after an error
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= mdsec_pkg::mdsec_st_wait;
    end else if (link_evt_i.pre_start) begin
      state_reg <= mdsec_pkg::mdsec_st_pre;
    end else begin
      case (state_reg)
        mdsec_pkg::mdsec_st_pre: begin
          if (link_evt_i.err) begin
            state_reg <= mdsec_pkg::mdsec_st_wait;
          end else if (link_evt_i.pre_ok) begin
            state_reg <= mdsec_pkg::mdsec_st_data;
          end
        end
        mdsec_pkg::mdsec_st_data: begin
          if (link_evt_i.err) begin
            state_reg <= mdsec_pkg::mdsec_st_wait;
          end else if (link_evt_i.data_ok) begin
            state_reg <= mdsec_pkg::mdsec_st_run;
          end
        end
        mdsec_pkg::mdsec_st_run: begin
          if (link_evt_i.err) begin
            state_reg <= mdsec_pkg::mdsec_st_wait;
          end
        end
        mdsec_pkg::mdsec_st_wait: begin
          state_reg <= mdsec_pkg::mdsec_st_wait;
        end
        default: begin
          state_reg <= mdsec_pkg::mdsec_st_wait;
        end
      endcase
    end
  end

  // transmit stays stopped after an error until the master restarts
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_enable_o <= 1'b0;
    end else if (pre_err_ev || data_err_ev) begin
      tx_enable_o <= 1'b0;
    end else if (link_evt_i.pre_start) begin
      tx_enable_o <= 1'b1;
    end
  end

  // active flag: set by the first completed data sequence, dropped by a data-sequence error or a new pre-sequence start
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_o.seq_active_flag <= 1'b0;
    end else if (data_err_ev || link_evt_i.pre_start) begin
      flags_o.seq_active_flag <= 1'b0;
    end else if (seq_up_ev) begin
      flags_o.seq_active_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_o.pre_seq_error_flag <= 1'b0;
    end else if (pre_err_ev) begin
      flags_o.pre_seq_error_flag <= 1'b1;
    end else if (link_evt_i.pre_ok && state_reg == mdsec_pkg::mdsec_st_pre) begin
      flags_o.pre_seq_error_flag <= 1'b0;
    end
  end

  // single slave clears at pre-sequence end, several slaves at first data end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_o.data_seq_error_flag <= 1'b0;
    end else if (data_err_ev) begin
      flags_o.data_seq_error_flag <= 1'b1;
    end else if (!multi_sync && link_evt_i.pre_ok &&
                 state_reg == mdsec_pkg::mdsec_st_pre) begin
      flags_o.data_seq_error_flag <= 1'b0;
    end else if (multi_sync && seq_up_ev) begin
      flags_o.data_seq_error_flag <= 1'b0;
    end
  end

  // lamp lit by any pre- or data-sequence error, dark again once both error flags are clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_error_lamp_o <= 1'b0;
    end else if (pre_err_ev || data_err_ev) begin
      link_error_lamp_o <= 1'b1;
    end else if (!flags_o.pre_seq_error_flag && !flags_o.data_seq_error_flag) begin
      link_error_lamp_o <= 1'b0;
    end
  end

  // configuration words are latched at the start of each pre-sequence
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_cfg_o <= `MDSEC_CFG_RST;
    end else if (link_evt_i.pre_start) begin
      op_cfg_o <= {buf_reg[IDX_CFG_LAST], buf_reg[IDX_CFG_FIRST + 7'h01],
                   buf_reg[IDX_CFG_FIRST]};
    end
  end

  // transmit area feeds the link; layout fixed whatever the master point count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_byte_o       <= 8'h00;
      tx_byte_valid_o <= 1'b0;
    end else begin
      tx_byte_valid_o <= link_evt_i.tx_req && tx_enable_o;
      if (link_evt_i.tx_req && tx_enable_o) begin
        tx_byte_o <= buf_reg[IDX_TX_BASE + {3'h0, link_evt_i.tx_idx}][7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // buffer memory
  // ---------------------------------------------------------------
  assign wr_fire   = aw_have_reg && w_have_reg && !s_axi_bvalid_o;
  assign wr_merged = {w_strb_reg[1] ? w_data_reg[15:8] : buf_reg[aw_idx_reg][15:8],
                      w_strb_reg[0] ? w_data_reg[7:0]  : buf_reg[aw_idx_reg][7:0]};

  // host may not touch the receive area or the error code word
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_reg[i] <= `MDSEC_WORD_RST;
      end
    end else begin
      if (wr_fire && aw_idx_reg <= IDX_BUF_LAST && aw_idx_reg != IDX_ERR_CODE &&
          !(aw_idx_reg >= IDX_RX_BASE && aw_idx_reg <= IDX_RX_LAST)) begin
        buf_reg[aw_idx_reg] <= wr_merged;
      end
      // receive data survives a data-sequence error
      if (link_evt_i.rx_we && state_reg != mdsec_pkg::mdsec_st_wait) begin
        buf_reg[IDX_RX_BASE + {2'h0, link_evt_i.rx_idx}] <= {8'h00, link_evt_i.rx_byte};
      end
      if (pre_err_ev || data_err_ev) begin
        buf_reg[IDX_ERR_CODE] <= link_evt_i.err_code;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[`MDSEC_IRQ_PRE_ERR]  = pre_err_ev;
    irq_set[`MDSEC_IRQ_DATA_ERR] = data_err_ev;
    irq_set[`MDSEC_IRQ_SEQ_UP]   = seq_up_ev;
    irq_clr = '0;
    if (wr_fire && aw_idx_reg == IDX_IRQ_STATUS && w_strb_reg[0]) begin
      irq_clr = w_data_reg[`MDSEC_IRQ_W-1:0];
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_reg <= `MDSEC_IRQ_RST;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask_reg <= `MDSEC_IRQ_RST;
    end else if (wr_fire && aw_idx_reg == IDX_IRQ_MASK && w_strb_reg[0]) begin
      irq_mask_reg <= w_data_reg[`MDSEC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path: address and data taken in either order
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have_reg     <= 1'b0;
      aw_idx_reg      <= 7'h00;
      s_axi_awready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_have_reg && !s_axi_awready_o && s_axi_awvalid_i;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr_i[8:2];
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_have_reg     <= 1'b0;
      w_data_reg     <= 16'h0000;
      w_strb_reg     <= 2'h0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_wready_o <= !w_have_reg && !s_axi_wready_o && s_axi_wvalid_i;
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i[15:0];
        w_strb_reg <= s_axi_wstrb_i[1:0];
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `MDSEC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (aw_idx_reg <= IDX_FLAGS) ? `MDSEC_RESP_OKAY : `MDSEC_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  assign ar_idx = s_axi_araddr_i[8:2];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b0;
    end else begin
      s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o && s_axi_arvalid_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `MDSEC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= `MDSEC_RESP_OKAY;
      s_axi_rdata_o  <= 32'h0000_0000;
      if (ar_idx <= IDX_BUF_LAST) begin
        s_axi_rdata_o <= {16'h0000, buf_reg[ar_idx]};
      end else if (ar_idx == IDX_IRQ_STATUS) begin
        s_axi_rdata_o <= {29'h0000_0000, irq_status_reg};
      end else if (ar_idx == IDX_IRQ_MASK) begin
        s_axi_rdata_o <= {29'h0000_0000, irq_mask_reg};
      end else if (ar_idx == IDX_FLAGS) begin
        s_axi_rdata_o <= {27'h0000_0000, tx_enable_o, multi_sync,
                          flags_o.data_seq_error_flag, flags_o.pre_seq_error_flag,
                          flags_o.seq_active_flag};
      end else begin
        s_axi_rresp_o <= `MDSEC_RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- mdsec_top_monitor.sv ----
// checker on the ports of the slave error control block
// assumes: bound to mdsec_top, one clock domain, reset active low
`timescale 1ns/1ps
`default_nettype none

module mdsec_top_monitor (
  input wire logic                       clk_i,
  input wire logic                       resetn_i,
  input wire mdsec_pkg::mdsec_link_evt_t link_evt_i,
  input wire logic                       tx_byte_valid_o,
  input wire logic                       tx_enable_o,
  input wire logic [47:0]                op_cfg_o,
  input wire mdsec_pkg::mdsec_flags_t    flags_o,
  input wire logic                       link_error_lamp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic hit;
  // an error seen while the link runs
  assign hit = link_evt_i.err && tx_enable_o && !link_evt_i.pre_start;

  property p_err_mark;
    hit |=> link_error_lamp_o
      && (flags_o.pre_seq_error_flag || flags_o.data_seq_error_flag);
  endproperty
  a_err_mark: assert property (p_err_mark) else $error("error left no flag");
  property p_tx_stop;
    hit |=> !tx_enable_o;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("transmit kept on");
  property p_data_err;
    hit && flags_o.seq_active_flag |=> flags_o.data_seq_error_flag
      && !flags_o.seq_active_flag;
  endproperty
  a_data_err: assert property (p_data_err) else $error("flags not swapped");
  property p_pre_clr;
    link_evt_i.pre_ok && tx_enable_o && !link_evt_i.err && !link_evt_i.pre_start
      |=> !flags_o.pre_seq_error_flag;
  endproperty
  a_pre_clr: assert property (p_pre_clr) else $error("pre flag stuck");
  property p_pre_low;
    link_evt_i.pre_start |=> !flags_o.seq_active_flag;
  endproperty
  a_pre_low: assert property (p_pre_low) else $error("active in pre");
  property p_tx_send;
    link_evt_i.tx_req && tx_enable_o && !link_evt_i.err |=> tx_byte_valid_o;
  endproperty
  a_tx_send: assert property (p_tx_send) else $error("byte not sent");
  property p_tx_quiet;
    !(link_evt_i.tx_req && tx_enable_o) && !link_evt_i.pre_start |=> !tx_byte_valid_o;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("stray byte");
  property p_cfg_hold;
    !link_evt_i.pre_start |=> $stable(op_cfg_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
  property p_act_up;
    $rose(flags_o.seq_active_flag) |-> $past(link_evt_i.data_ok);
  endproperty
  a_act_up: assert property (p_act_up) else $error("active without data");

  c_err: cover property (hit);
  c_up: cover property ($rose(flags_o.seq_active_flag));
  c_clr: cover property ($fell(flags_o.data_seq_error_flag));
endmodule

bind mdsec_top mdsec_top_monitor i_mon (
  .clk_i, .resetn_i, .link_evt_i, .tx_byte_valid_o, .tx_enable_o,
  .op_cfg_o, .flags_o, .link_error_lamp_o
);

`default_nettype wire

// ---- mdsec_top_tb.sv ----
// bench for the slave error control block: host over AXI4-Lite, master model
// assumes: mdsec_pkg, the design and the master model are compiled first
`timescale 1ns/1ps
`default_nettype none

module mdsec_top_tb;
  logic                       clk_i = 1'b0;
  logic                       resetn = 1'b0;
  logic [8:0]                 awaddr = '0, araddr = '0;
  logic [31:0]                wdata = '0, rdata;
  logic [3:0]                 wstrb = '0;
  logic                       awvalid = 0, wvalid = 0, bready = 0;
  logic                       arvalid = 0, rready = 0, multi = 0;
  logic                       awready, wready, bvalid, arready, rvalid;
  logic [1:0]                 bresp, rresp;
  logic [7:0]                 txb;
  logic                       txv, txe, lamp, irq;
  logic [47:0]                cfg;
  mdsec_pkg::mdsec_flags_t    flags;
  mdsec_pkg::mdsec_link_evt_t evt;
  int                         err_count = 0, n_checks = 0;

  always #12.5 clk_i = ~clk_i;

  mdsec_master_model i_mst (.clk_i(clk_i), .evt_o(evt));
  mdsec_top i_dut (
    .clk_i(clk_i), .resetn_i(resetn),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .link_evt_i(evt),
    .multi_slave_select_switch_i(multi), .tx_byte_o(txb), .tx_byte_valid_o(txv),
    .tx_enable_o(txe), .op_cfg_o(cfg), .flags_o(flags),
    .link_error_lamp_o(lamp), .irq_o(irq)
  );

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic ck(input logic [47:0] g, input logic [47:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tmo;
    err_count++;
    $display("Error at %0t: no bus answer", $time);
    give_verdict();
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [1:0] r);
    int i;
    @(posedge clk_i);
    awaddr <= {a, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 40) tmo();
    bready <= 1'b0;
    ck({46'h0, bresp}, {46'h0, r});
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic [1:0] r);
    int i;
    @(posedge clk_i);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 40) tmo();
    rready <= 1'b0;
    ck({16'h0, rdata}, {32'h0, e});
    ck({46'h0, rresp}, {46'h0, r});
  endtask
  // flags as {data error, pre error, active}
  task automatic fl(input logic [2:0] f);
    @(negedge clk_i);
    ck({45'h0, flags}, {45'h0, f});
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    resetn <= 1'b1;
    rd(7'h50, 16'h0000, 2'h0);
    rd(7'h70, 16'h0000, 2'h2);
    wr(7'h70, 16'h0001, 2'h2);
    wr(7'h00, 16'h1111, 2'h0);
    wr(7'h01, 16'h2222, 2'h0);
    wr(7'h02, 16'h3333, 2'h0);
    wr(7'h30, 16'h00A5, 2'h0);
    wr(7'h61, 16'h0007, 2'h0);
    i_mst.ev(0, 16'h0000);
    fl(3'b000);
    ck(cfg, 48'h3333_2222_1111);
    ck({47'h0, txe}, 48'h1);
    i_mst.ev(1, 16'h0000);
    i_mst.ev(2, 16'h0000);
    fl(3'b001);
    i_mst.ev(4, 16'h003C);
    rd(7'h10, 16'h003C, 2'h0);
    ck({47'h0, irq}, 48'h1);
    wr(7'h10, 16'hFFFF, 2'h0);
    i_mst.ev(5, 16'h0000);
    @(negedge clk_i);
    ck({39'h0, txv, txb}, 48'h1A5);
    i_mst.ev(3, 16'h1234);
    fl(3'b100);
    ck({46'h0, lamp, txe}, 48'h2);
    rd(7'h50, 16'h1234, 2'h0);
    rd(7'h10, 16'h003C, 2'h0);
    rd(7'h60, 16'h0006, 2'h0);
    wr(7'h60, 16'h0006, 2'h0);
    rd(7'h60, 16'h0000, 2'h0);
    ck({47'h0, irq}, 48'h0);
    i_mst.ev(3, 16'h0077);
    i_mst.ev(0, 16'h0000);
    i_mst.ev(1, 16'h0000);
    fl(3'b000);
    i_mst.ev(2, 16'h0000);
    fl(3'b001);
    ck({47'h0, lamp}, 48'h0);
    rd(7'h50, 16'h1234, 2'h0);
    i_mst.ev(0, 16'h0000);
    i_mst.ev(3, 16'h0055);
    fl(3'b010);
    ck({46'h0, lamp, txe}, 48'h2);
    rd(7'h50, 16'h0055, 2'h0);
    rd(7'h60, 16'h0005, 2'h0);
    rd(7'h62, 16'h0002, 2'h0);
    i_mst.ev(5, 16'h0000);
    @(negedge clk_i);
    ck({47'h0, txv}, 48'h0);
    i_mst.ev(0, 16'h0000);
    i_mst.ev(1, 16'h0000);
    fl(3'b000);
    wr(7'h61, 16'h0000, 2'h0);
    multi <= 1'b1;
    i_mst.ev(2, 16'h0000);
    i_mst.ev(3, 16'h0042);
    fl(3'b100);
    i_mst.ev(0, 16'h0000);
    i_mst.ev(1, 16'h0000);
    fl(3'b100);
    ck({47'h0, irq}, 48'h0);
    i_mst.ev(2, 16'h0000);
    fl(3'b001);
    rd(7'h62, 16'h0019, 2'h0);
    wr(7'h31, 16'h00C3, 2'h0);
    i_mst.ev(4, 16'h0166);
    @(posedge clk_i);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn <= 1'b1;
    rd(7'h11, 16'h0000, 2'h0);
    rd(7'h31, 16'h0000, 2'h0);
    rd(7'h50, 16'h0000, 2'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
